// File: design/sgl_desc_decode.sv
// decodes one 16-byte descriptor into fields and error flags
`timescale 1ns/1ps
`default_nettype none
module sgl_desc_decode
    import sgl_pkg::*;
(
    input wire logic [127:0] desc,
    output logic [63:0] addr,
    output logic [31:0] len,
    output logic [3:0] dtype,
    output logic is_seg,
    output logic is_last,
    output logic type_err,
    output logic overflow,
    output logic len_field_bad
);
    logic [64:0] end_addr;
    always_comb begin
        addr = desc[ADDR_LSB +: 64];
        len = desc[LEN_LSB +: 32];
        // bytes 14..12 are not looked at
        dtype = desc[ID_LSB+4 +: 4];
        is_seg = (dtype == TYPE_SEG);
        is_last = (dtype == TYPE_LAST);
        type_err = (is_seg || is_last) && (desc[ID_LSB +: 4] != ZERO_OK);
        end_addr = {1'b0, addr} + {33'h0, len};
        // exactly 2^64 is still legal, only beyond it overflows
        overflow = end_addr[64] && (end_addr[63:0] != 64'h0);
        len_field_bad = (len == 32'h0) || ((len[3:0] & SEG_ALIGN_MASK) != 4'h0);
    end
endmodule
`default_nettype wire

// File: design/sgl_meta_check.sv
// metadata pointer and protection-information offset selection
`timescale 1ns/1ps
`default_nettype none
module sgl_meta_check
    import sgl_pkg::*;
(
    input wire logic [63:0] md_ptr,
    input wire logic separate_md,
    input wire logic pi_enable,
    input wire logic pi_at_end,
    input wire logic [15:0] md_size,
    output logic ptr_misaligned,
    output logic [15:0] pi_offset
);
    always_comb begin
        ptr_misaligned = separate_md && ((md_ptr[1:0] & PTR_ALIGN_MASK) != 2'h0);
        pi_offset = 16'h0;
        if (pi_enable && pi_at_end) begin
            pi_offset = md_size - 16'(PI_BYTES);
        end
    end
endmodule
`default_nettype wire

// File: design/sgl_segment_descriptor_check.sv
// scatter-gather segment descriptor checker with register port
// Notes on behaviour
// - address bytes 7..0, length bytes 11..8
// - address plus length beyond 2^64 errors
// - identifier high nibble 2h: non-final segment
// - identifier high nibble 3h: final segment
// - non-final segment nonzero low nibble: type error
// - final segment nonzero low nibble: type error
// - segment pointer inside final segment errors
// - metadata never split between block and buffer
// - block and metadata committed together
// - separate metadata found through command pointer
// - protection taken from first or last eight
// - discard length counts only in destination lists
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sgl_segment_descriptor_check
    import sgl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic desc_valid,
    input wire logic [127:0] desc,
    input wire logic seg_end,
    input wire logic block_done,
    input wire logic meta_done,
    output logic fetch_req,
    output logic [63:0] fetch_addr,
    output logic [31:0] fetch_len,
    output logic commit,
    output logic [15:0] pi_offset,
    output logic irq
);
    typedef struct packed {
        walk_t state;
        logic [31:0] ctrl;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [31:0] lb_count;
        logic [63:0] md_ptr;
        logic [63:0] next_addr;
        logic [31:0] next_len;
        logic fetch;
        logic blk_seen;
        logic md_seen;
        logic commit;
        logic [15:0] pi_off;
        logic [31:0] rdata;
        logic irq;
    } state_t;

    state_t s_q, s_d;

    logic [63:0] d_addr;
    logic [31:0] d_len;
    logic [3:0] d_type;
    logic d_seg, d_last, d_type_err, d_ovf, d_len_bad;
    logic md_mis;
    logic [15:0] pi_calc;
    logic [ST_W-1:0] ev;

    // ctrl: 0 start, 1 metadata list, 2 separate metadata, 3 destination list,
    // 4 pi enable, 5 pi at end, 31:16 metadata size
    sgl_desc_decode u_dec (
        .desc(desc),
        .addr(d_addr),
        .len(d_len),
        .dtype(d_type),
        .is_seg(d_seg),
        .is_last(d_last),
        .type_err(d_type_err),
        .overflow(d_ovf),
        .len_field_bad(d_len_bad)
    );

    sgl_meta_check u_meta (
        .md_ptr(s_q.md_ptr),
        .separate_md(s_q.ctrl[2]),
        .pi_enable(s_q.ctrl[4]),
        .pi_at_end(s_q.ctrl[5]),
        .md_size(s_q.ctrl[31:16]),
        .ptr_misaligned(md_mis),
        .pi_offset(pi_calc)
    );

    always_comb begin
        s_d = s_q;
        ev = '0;
        s_d.fetch = 1'b0;
        s_d.commit = 1'b0;
        s_d.rdata = 32'h0;
        s_d.pi_off = pi_calc;

        case (s_q.state)
            IDLE: begin
                if (reg_wr && reg_addr == REG_CTRL && reg_wdata[0]) begin
                    s_d.state = WALK;
                    s_d.blk_seen = 1'b0;
                    s_d.md_seen = 1'b0;
                    ev[ST_MDPTR] = reg_wdata[2] && (s_q.md_ptr[1:0] != 2'h0);
                end
            end
            WALK, FINAL: begin
                if (desc_valid) begin
                    if (d_seg || d_last) begin
                        if (s_q.state == FINAL) begin
                            ev[ST_LAST_NEST] = 1'b1;
                            s_d.state = DONE;
                        end else if (d_type_err) begin
                            ev[ST_TYPE] = 1'b1;
                            s_d.state = DONE;
                        end else if (d_ovf) begin
                            ev[s_q.ctrl[1] ? ST_LEN_META : ST_LEN_DATA] = 1'b1;
                            s_d.state = DONE;
                        end else begin
                            // host-side length fault is recorded but not fatal
                            ev[ST_LEN_FIELD] = d_len_bad;
                            s_d.next_addr = d_addr;
                            s_d.next_len = d_len;
                            s_d.fetch = 1'b1;
                            if (d_last) begin
                                s_d.state = FINAL;
                            end
                        end
                    end else if (d_type == TYPE_DISCARD && s_q.ctrl[3]) begin
                        s_d.lb_count = s_q.lb_count + d_len;
                    end
                end else if (seg_end && s_q.state == FINAL) begin
                    s_d.state = DONE;
                    ev[ST_DONE] = 1'b1;
                end
            end
            DONE: begin
                s_d.state = IDLE;
            end
            default: begin
                s_d.state = IDLE;
            end
        endcase

        // in separate-metadata mode hold block until its metadata also arrives, then commit both at once; otherwise commit on block alone
        if (block_done) begin
            s_d.blk_seen = 1'b1;
        end
        // metadata arrival is latched only in separate-buffer mode, so a mode
        // switch cannot leave a stale flag behind that commits a block early
        if (meta_done && s_q.ctrl[2]) begin
            s_d.md_seen = 1'b1;
        end
        if (s_d.blk_seen && (s_d.md_seen || !s_q.ctrl[2])) begin
            s_d.commit = 1'b1;
            s_d.blk_seen = 1'b0;
            s_d.md_seen = 1'b0;
        end
        // a pointer rewritten mid-list is checked again
        ev[ST_MDPTR] = ev[ST_MDPTR] | (s_q.state != IDLE && md_mis);

        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: s_d.ctrl = reg_wdata;
                REG_STATUS: s_d.status = s_q.status & ~reg_wdata[ST_W-1:0];
                REG_MASK: s_d.mask = reg_wdata[ST_W-1:0];
                REG_LBCOUNT: s_d.lb_count = reg_wdata;
                REG_MDPTR_LO: s_d.md_ptr[31:0] = reg_wdata;
                REG_MDPTR_HI: s_d.md_ptr[63:32] = reg_wdata;
                default: ;
            endcase
        end
        // set wins over a write-one clear in the same cycle
        s_d.status = s_d.status | ev;
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: s_d.rdata = s_q.ctrl;
                REG_STATUS: s_d.rdata = {25'h0, s_q.status};
                REG_MASK: s_d.rdata = {25'h0, s_q.mask};
                REG_LBCOUNT: s_d.rdata = s_q.lb_count;
                REG_MDPTR_LO: s_d.rdata = s_q.md_ptr[31:0];
                REG_MDPTR_HI: s_d.rdata = s_q.md_ptr[63:32];
                REG_NEXT_LO: s_d.rdata = s_q.next_addr[31:0];
                REG_NEXT_HI: s_d.rdata = s_q.next_addr[63:32];
                REG_NEXT_LEN: s_d.rdata = s_q.next_len;
                REG_STATE: s_d.rdata = {30'h0, s_q.state};
                default: s_d.rdata = 32'h0;
            endcase
        end
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.state <= IDLE;
            s_q.ctrl <= CTRL_RST;
            s_q.status <= STATUS_RST;
            s_q.mask <= MASK_RST;
            s_q.lb_count <= LBCOUNT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        reg_rdata = s_q.rdata;
        fetch_req = s_q.fetch;
        fetch_addr = s_q.next_addr;
        fetch_len = s_q.next_len;
        commit = s_q.commit;
        pi_offset = s_q.pi_off;
        irq = s_q.irq;
    end
endmodule
`default_nettype wire

// File: shared/sgl_pkg.sv
// shared constants and types for the segment descriptor checker
package sgl_pkg;
    // descriptor byte layout
    localparam int ADDR_LSB = 0;
    localparam int LEN_LSB = 64;
    localparam int ID_LSB = 120;
    localparam logic [3:0] TYPE_DISCARD = 4'h1;
    localparam logic [3:0] TYPE_SEG = 4'h2;
    localparam logic [3:0] TYPE_LAST = 4'h3;
    localparam logic [3:0] ZERO_OK = 4'h0;
    localparam logic [3:0] SEG_ALIGN_MASK = 4'hf;
    localparam logic [1:0] PTR_ALIGN_MASK = 2'h3;
    localparam int PI_BYTES = 8;
    // register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_MASK = 4'h2;
    localparam logic [3:0] REG_LBCOUNT = 4'h3;
    localparam logic [3:0] REG_MDPTR_LO = 4'h4;
    localparam logic [3:0] REG_MDPTR_HI = 4'h5;
    localparam logic [3:0] REG_NEXT_LO = 4'h6;
    localparam logic [3:0] REG_NEXT_HI = 4'h7;
    localparam logic [3:0] REG_NEXT_LEN = 4'h8;
    localparam logic [3:0] REG_STATE = 4'h9;
    // status bit positions
    localparam int ST_LEN_DATA = 0;
    localparam int ST_LEN_META = 1;
    localparam int ST_TYPE = 2;
    localparam int ST_LAST_NEST = 3;
    localparam int ST_LEN_FIELD = 4;
    localparam int ST_MDPTR = 5;
    localparam int ST_DONE = 6;
    localparam int ST_W = 7;
    localparam logic [ST_W-1:0] STATUS_RST = 7'h00;
    localparam logic [ST_W-1:0] MASK_RST = 7'h00;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] LBCOUNT_RST = 32'h0000_0000;
    typedef enum logic [1:0] {IDLE, WALK, FINAL, DONE} walk_t;
endpackage

// File: verif/host_model.sv
// host side model: hands descriptors that software built in memory to the block
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clock,
    output logic desc_valid,
    output logic [127:0] desc
);
    initial begin
        desc_valid = 1'b0;
        desc = 128'h0;
    end
    // released lines show the inverse so a late sample cannot pass by luck
    task automatic send(input logic [63:0] a, input logic [31:0] l, input logic [7:0] id);
        @(posedge clock);
        desc <= {id, 24'h0, l, a};
        desc_valid <= 1'b1;
        @(posedge clock);
        desc_valid <= 1'b0;
        desc <= ~{id, 24'h0, l, a};
    endtask
endmodule
`default_nettype wire

// File: verif/sgl_check_checker.sv
// port assertions for the segment descriptor checker
`timescale 1ns/1ps
`default_nettype none
module sgl_check_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic desc_valid,
    input wire logic seg_end,
    input wire logic block_done,
    input wire logic meta_done,
    input wire logic fetch_req,
    input wire logic [63:0] fetch_addr,
    input wire logic [31:0] fetch_len,
    input wire logic commit,
    input wire logic [15:0] pi_offset,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic ev = desc_valid | seg_end | reg_wr;
    property p_fetch; fetch_req |-> $past(desc_valid) ##1 !fetch_req; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch without descriptor");
    property p_wrap;
        fetch_req |-> {1'b0, fetch_addr} + {33'h0, fetch_len} <= 65'h1_0000_0000_0000_0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("fetch beyond top");
    property p_hold; $changed(fetch_addr) || $changed(fetch_len) |-> fetch_req; endproperty
    a_hold: assert property (p_hold) else $error("fetch fields moved");
    property p_commit;
        commit |-> ($past(block_done) || $past(meta_done)) ##1 !commit;
    endproperty
    a_commit: assert property (p_commit) else $error("commit without cause");
    property p_irq; $rose(irq) |-> $past(ev) || $past(ev, 2) || $past(ev, 3); endproperty
    a_irq: assert property (p_irq) else $error("interrupt without event");
    property p_irq_off; $fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt dropped alone");
    property p_pi; $changed(pi_offset) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
    a_pi: assert property (p_pi) else $error("offset moved alone");
    property p_rd; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule
bind sgl_segment_descriptor_check sgl_check_checker u_chk (.*);
`default_nettype wire

// File: verif/test_sgl_segment_descriptor_check.sv
// self-checking bench for the segment descriptor checker
`timescale 1ns/1ps
`default_nettype none
module test_sgl_segment_descriptor_check;
    import sgl_pkg::*;
    localparam logic [63:0] TOP = 64'hffff_ffff_ffff_fff0;
    logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic seg_end = 1'b0, block_done = 1'b0, meta_done = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, fetch_len;
    logic [127:0] desc;
    logic [63:0] fetch_addr;
    logic [15:0] pi_offset;
    logic desc_valid, fetch_req, commit, irq;
    int n_errors = 0;
    int n_tests = 0;
    always #12.5 clock = ~clock;
    sgl_segment_descriptor_check dut (.*);
    host_model host (.clock, .desc_valid, .desc);
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk("register", 64'(exp), 64'(reg_rdata & m));
    endtask
    task automatic strobe(input int k);
        @(posedge clock);
        block_done <= k == 0;
        meta_done <= k == 1;
        seg_end <= k == 2;
        @(posedge clock);
        {block_done, meta_done, seg_end} <= 3'h0;
    endtask
    // bounded wait: a pulse that never comes ends the run
    task automatic wpulse(ref logic s, input string n);
        int i;
        i = 0;
        // look at the cycle already under way first: the pulse may stand now
        #1;
        while (s !== 1'b1 && i < 8) begin
            @(posedge clock);
            #1;
            i++;
        end
        chk(n, 64'h1, 64'(s));
        if (s !== 1'b1) wrap_up();
    endtask
    task automatic reset_dut(input int n);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (n) @(posedge clock);
        rst_n <= 1'b1;
    endtask
    task automatic run(input string n, input logic [31:0] ctrl, input logic [31:0] md,
            input logic [63:0] a, input logic [31:0] l, input logic [7:0] id1,
            input logic [7:0] id2, input logic [31:0] m, input logic [31:0] exp);
        reset_dut(2);
        wr(REG_MDPTR_LO, md);
        wr(REG_CTRL, ctrl);
        if (id1 != 8'h0) host.send(a, l, id1);
        if (id2 != 8'h0) host.send(64'h2000, 32'h20, id2);
        repeat (3) @(posedge clock);
        rc(REG_STATUS, m, exp);
        $display("test %s done", n);
    endtask
    initial begin
        reset_dut(6);
        rc(4'hf, 32'hffff_ffff, 32'h0);
        rc(REG_LBCOUNT, 32'hffff_ffff, LBCOUNT_RST);
        wr(REG_MASK, 32'h7f);
        wr(REG_CTRL, 32'h1);
        host.send(64'h1000, 32'h40, 8'h20);
        wpulse(fetch_req, "fetch");
        chk("fetch addr", 64'h1000, fetch_addr);
        chk("fetch len", 64'h40, 64'(fetch_len));
        host.send(64'h3000, 32'h20, 8'h30);
        wpulse(fetch_req, "fetch");
        chk("fetch addr", 64'h3000, fetch_addr);
        strobe(2);
        rc(REG_STATUS, 32'h7f, 32'h40);
        chk("irq", 64'h1, 64'(irq));
        wr(REG_MASK, 32'h0);
        rc(REG_STATUS, 32'h7f, 32'h40);
        chk("irq", 64'h0, 64'(irq));
        wr(REG_STATUS, 32'h7f);
        rc(REG_STATUS, 32'h7f, 32'h0);
        $display("test walk done");
        run("type seg", 32'h1, 32'h0, 64'h1000, 32'h40, 8'h21, 8'h0, 32'h4, 32'h4);
        run("type last", 32'h1, 32'h0, 64'h1000, 32'h40, 8'h3f, 8'h0, 32'h4, 32'h4);
        run("wrap data", 32'h1, 32'h0, TOP, 32'h20, 8'h20, 8'h0, 32'h3, 32'h1);
        run("wrap meta", 32'h3, 32'h0, TOP, 32'h20, 8'h20, 8'h0, 32'h3, 32'h2);
        run("top edge", 32'h1, 32'h0, TOP, 32'h10, 8'h20, 8'h0, 32'h3, 32'h0);
        run("nest", 32'h1, 32'h0, 64'h1000, 32'h20, 8'h30, 8'h20, 32'h8, 32'h8);
        run("md odd", 32'h5, 32'h2, 64'h0, 32'h0, 8'h0, 8'h0, 32'h20, 32'h20);
        run("md ok", 32'h5, 32'h4, 64'h0, 32'h0, 8'h0, 8'h0, 32'h20, 32'h0);
        run("bucket dst", 32'h9, 32'h0, 64'h0, 32'h800, 8'h10, 8'h0, 32'h0, 32'h0);
        rc(REG_LBCOUNT, 32'hffff_ffff, 32'h800);
        run("bucket src", 32'h1, 32'h0, 64'h0, 32'h800, 8'h10, 8'h0, 32'h0, 32'h0);
        rc(REG_LBCOUNT, 32'hffff_ffff, 32'h0);
        wr(REG_CTRL, 32'h0010_0034);
        strobe(0);
        strobe(1);
        wpulse(commit, "commit pair");
        chk("pi offset", 64'h8, 64'(pi_offset));
        wr(REG_CTRL, 32'h0010_0010);
        strobe(0);
        wpulse(commit, "commit block");
        chk("pi offset", 64'h0, 64'(pi_offset));
        $display("test commit done");
        wrap_up();
    end
endmodule
`default_nettype wire
